// ### hw/sts_semaphore_events.sv
// Semaphore, task, event, shortcut, channel-link and interrupt logic of the SPI target.
//
// How it works
// [R1] Writing one to the give trigger frees the semaphore for the engine.
// [R2] Writing one to the take trigger requests ownership; granted when engine is idle.
// [R3] Take channel link holds index and enable; disabled links never trigger.
// [R4] Give channel link with same layout lets a channel trigger the give task.
// [R5] Receive-end flag sets on buffer end, reads zero otherwise, cleared writing zero.
// [R6] Semaphore-taken flag sets whenever the processor actually gains ownership.
// [R7] Each of three events has a link publishing it onto a chosen channel.
// [R8] With the shortcut bit set, each done event triggers the take task.
// [R9] Done flag sets when a transaction granted to the engine finishes.
// [R10] Enable-set receive-end bit written one enables; reads return the enable.
// [R11] Enable-set taken bit written one enables; reads return the enable.
// [R12] Task registers are write-only triggers reading zero; a one starts the task.
// [R13] Enable-clear register disables on one; reads mirror the shared enables.
// [R14] Owner field reads 0 free, 1 processor, 2 engine, 3 engine with handover.
// [R15] Status bits flag prevented over-read and overflow; cleared by writing one.
//
// Register access over APB was left to the implementer.
`default_nettype none
module sts_semaphore_events #(
  parameter int NUM_CHAN = 256
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic spi_csn_i,
  input wire logic spi_sck_i,
  input wire logic rx_end_i,
  input wire logic tx_overrun_read_i,
  input wire logic overflow_i,
  input wire logic [NUM_CHAN-1:0] chan_i,
  output logic [NUM_CHAN-1:0] chan_o,
  output logic engine_owns_o,
  output logic irq_o
);

  // Index field is eight bits wide, so more channels than that cannot be named.
  if (NUM_CHAN < 1 || NUM_CHAN > 256)
  begin : g_chan_check
    $error("NUM_CHAN must lie between 1 and 256.");
  end

  // Returns one when a channel link is enabled and its channel pulses.
  function automatic logic link_hit(input sts_pkg::sts_link_type link,
                                    input logic [NUM_CHAN-1:0] chan);
    logic hit;
    hit = 1'b0;
    if (link.en && (int'(link.idx) < NUM_CHAN))
    begin
      hit = chan[link.idx];
    end
    return hit;
  endfunction

  // One-hot channel vector for an event published through a link.
  function automatic logic [NUM_CHAN-1:0] link_drive(input sts_pkg::sts_link_type link,
                                                     input logic fire);
    logic [NUM_CHAN-1:0] vec;
    vec = '0;
    if (fire && link.en && (int'(link.idx) < NUM_CHAN))
    begin
      vec[link.idx] = 1'b1;
    end
    return vec;
  endfunction

  // Packs a link into its 32-bit register image.
  function automatic logic [31:0] link_word(input sts_pkg::sts_link_type link);
    logic [31:0] w;
    w = sts_pkg::RST_ZERO;
    w[sts_pkg::LINK_EN_BIT] = link.en;
    w[sts_pkg::LINK_IDX_W-1:0] = link.idx;
    return w;
  endfunction

  // Unpacks a written word into a link.
  function automatic sts_pkg::sts_link_type word_link(input logic [31:0] w);
    sts_pkg::sts_link_type link;
    link.en = w[sts_pkg::LINK_EN_BIT];
    link.idx = w[sts_pkg::LINK_IDX_W-1:0];
    return link;
  endfunction

  sts_pkg::sts_sem_type sem;
  sts_pkg::sts_sem_type next_sem;
  sts_pkg::sts_link_type sub_take;
  sts_pkg::sts_link_type sub_give;
  sts_pkg::sts_link_type pub_done;
  sts_pkg::sts_link_type pub_rxend;
  sts_pkg::sts_link_type pub_taken;
  sts_pkg::sts_evt_type ev_flag;
  sts_pkg::sts_evt_type ev_pulse;
  sts_pkg::sts_evt_type irq_en;
  sts_pkg::sts_evt_type irq_pend;
  logic short_done_take;
  logic stat_tx_overrun_read;
  logic stat_overflow;
  logic [sts_pkg::BITCNT_W-1:0] bit_cnt;
  logic csn_meta;
  logic csn_sync;
  logic csn_prev;
  logic sck_meta;
  logic sck_sync;
  logic sck_prev;
  logic csn_fall;
  logic csn_rise;
  logic sck_rise;
  logic wr_acc;
  logic setup;
  logic mapped;
  logic sw_take;
  logic sw_give;
  logic take_req;
  logic give_req;
  logic [31:0] rd_val;

  // Serial pins come from the master's domain, so each passes two flops first.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      csn_meta <= 1'b1;
      csn_sync <= 1'b1;
      csn_prev <= 1'b1;
      sck_meta <= 1'b0;
      sck_sync <= 1'b0;
      sck_prev <= 1'b0;
    end
    else
    begin
      csn_meta <= spi_csn_i;
      csn_sync <= csn_meta;
      csn_prev <= csn_sync;
      sck_meta <= spi_sck_i;
      sck_sync <= sck_meta;
      sck_prev <= sck_sync;
    end
  end

  // Edges of the synchronised select and clock.
  assign csn_fall = csn_prev & ~csn_sync;
  assign csn_rise = ~csn_prev & csn_sync;
  assign sck_rise = ~sck_prev & sck_sync;

  // The bus answers in the access phase; the read word is latched in setup.
  assign setup = psel_i & ~penable_i;
  assign wr_acc = psel_i & penable_i & pwrite_i;
  assign pready_o = psel_i & penable_i;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // Address decode, also used to flag unmapped accesses.
  always_comb
  begin
    mapped = 1'b1;
    if (paddr_i == sts_pkg::OFS_TAKE || paddr_i == sts_pkg::OFS_GIVE)
    begin
      rd_val = sts_pkg::RST_ZERO; // [R12]
    end
    else if (paddr_i == sts_pkg::OFS_SUB_TAKE)
    begin
      rd_val = link_word(sub_take);
    end
    else if (paddr_i == sts_pkg::OFS_SUB_GIVE)
    begin
      rd_val = link_word(sub_give);
    end
    else if (paddr_i == sts_pkg::OFS_EV_DONE)
    begin
      rd_val = {31'h0000_0000, ev_flag.done};
    end
    else if (paddr_i == sts_pkg::OFS_EV_RXEND)
    begin
      rd_val = {31'h0000_0000, ev_flag.rx_end}; // [R5]
    end
    else if (paddr_i == sts_pkg::OFS_EV_TAKEN)
    begin
      rd_val = {31'h0000_0000, ev_flag.taken};
    end
    else if (paddr_i == sts_pkg::OFS_PUB_DONE)
    begin
      rd_val = link_word(pub_done);
    end
    else if (paddr_i == sts_pkg::OFS_PUB_RXEND)
    begin
      rd_val = link_word(pub_rxend);
    end
    else if (paddr_i == sts_pkg::OFS_PUB_TAKEN)
    begin
      rd_val = link_word(pub_taken);
    end
    else if (paddr_i == sts_pkg::OFS_EVENT_TASK_SHORTCUTS)
    begin
      rd_val = sts_pkg::RST_ZERO;
      rd_val[sts_pkg::SHORT_DONE_TAKE_BIT] = short_done_take;
    end
    else if (paddr_i == sts_pkg::OFS_IRQ_PEND)
    begin
      rd_val = {29'h0000_0000, irq_pend};
    end
    else if (paddr_i == sts_pkg::OFS_IEN_SET || paddr_i == sts_pkg::OFS_IEN_CLR)
    begin
      rd_val = {29'h0000_0000, irq_en}; // [R10] [R11] [R13]
    end
    else if (paddr_i == sts_pkg::OFS_OWNER)
    begin
      rd_val = {30'h0000_0000, sem}; // [R14]
    end
    else if (paddr_i == sts_pkg::OFS_STATUS)
    begin
      rd_val = sts_pkg::RST_ZERO;
      rd_val[sts_pkg::STAT_TX_OVERRUN_READ_BIT] = stat_tx_overrun_read;
      rd_val[sts_pkg::STAT_OVERFLOW_BIT] = stat_overflow;
    end
    else if (paddr_i == sts_pkg::OFS_BITCNT)
    begin
      rd_val = {16'h0000, bit_cnt};
    end
    else
    begin
      rd_val = sts_pkg::RST_ZERO;
      mapped = 1'b0;
    end
  end

  // Read data is captured in the setup cycle and held through the access phase.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prdata_o <= sts_pkg::RST_ZERO;
    end
    else if (setup && !pwrite_i)
    begin
      prdata_o <= rd_val;
    end
  end

  // Task triggers: software writes, subscribed channels and the shortcut.
  assign sw_take = wr_acc && paddr_i == sts_pkg::OFS_TAKE && pwdata_i[sts_pkg::TRIG_BIT]; // [R2]
  assign sw_give = wr_acc && paddr_i == sts_pkg::OFS_GIVE && pwdata_i[sts_pkg::TRIG_BIT]; // [R1]
  // The shortcut is applied inside the owner machine, so the take request never
  // depends on the done pulse and no combinational loop can form.
  assign take_req = sw_take | link_hit(sub_take, chan_i); // [R3]
  assign give_req = sw_give | link_hit(sub_give, chan_i); // [R4]

  // Semaphore owner. A transaction is granted only when the select falls while
  // the semaphore is free; a select that falls while the processor holds it is
  // ignored by this block and raises no done event.
  always_comb
  begin
    next_sem = sem;
    ev_pulse.done = 1'b0;
    ev_pulse.taken = 1'b0;
    ev_pulse.rx_end = rx_end_i; // [R5]
    case (sem)
      sts_pkg::SEM_FREE:
      begin
        if (csn_fall)
        begin
          next_sem = sts_pkg::SEM_ENG;
        end
        else if (take_req)
        begin
          next_sem = sts_pkg::SEM_CPU; // [R2]
          ev_pulse.taken = 1'b1; // [R6]
        end
      end
      sts_pkg::SEM_CPU:
      begin
        if (give_req)
        begin
          next_sem = sts_pkg::SEM_FREE; // [R1]
        end
      end
      sts_pkg::SEM_ENG:
      begin
        if (csn_rise)
        begin
          ev_pulse.done = 1'b1; // [R9]
          next_sem = sts_pkg::SEM_FREE;
          if (short_done_take || take_req)
          begin
            next_sem = sts_pkg::SEM_CPU; // [R8]
            ev_pulse.taken = 1'b1; // [R6]
          end
        end
        else if (take_req)
        begin
          next_sem = sts_pkg::SEM_PEND; // [R2]
        end
      end
      default:
      begin
        if (csn_rise)
        begin
          ev_pulse.done = 1'b1; // [R9]
          next_sem = sts_pkg::SEM_CPU;
          ev_pulse.taken = 1'b1; // [R6]
        end
        else if (give_req)
        begin
          next_sem = sts_pkg::SEM_ENG;
        end
      end
    endcase
  end

  // The processor owns the buffers out of reset.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sem <= sts_pkg::SEM_RESET;
    end
    else
    begin
      sem <= next_sem; // [R14]
    end
  end

  // The engine keeps the buffers in both engine states.
  assign engine_owns_o = sem[1];

  // Counts rising clock edges of the granted transaction; cleared when one is granted.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bit_cnt <= '0;
    end
    else if (sem == sts_pkg::SEM_FREE && csn_fall)
    begin
      bit_cnt <= '0;
    end
    else if (sem[1] && sck_rise && bit_cnt != '1)
    begin
      bit_cnt <= bit_cnt + 16'h0001;
    end
  end

  // Channel and shortcut configuration registers.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sub_take <= '0;
      sub_give <= '0;
      pub_done <= '0;
      pub_rxend <= '0;
      pub_taken <= '0;
      short_done_take <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (paddr_i == sts_pkg::OFS_SUB_TAKE)
      begin
        sub_take <= word_link(pwdata_i); // [R3]
      end
      else if (paddr_i == sts_pkg::OFS_SUB_GIVE)
      begin
        sub_give <= word_link(pwdata_i); // [R4]
      end
      else if (paddr_i == sts_pkg::OFS_PUB_DONE)
      begin
        pub_done <= word_link(pwdata_i); // [R7]
      end
      else if (paddr_i == sts_pkg::OFS_PUB_RXEND)
      begin
        pub_rxend <= word_link(pwdata_i); // [R7]
      end
      else if (paddr_i == sts_pkg::OFS_PUB_TAKEN)
      begin
        pub_taken <= word_link(pwdata_i); // [R7]
      end
      else if (paddr_i == sts_pkg::OFS_EVENT_TASK_SHORTCUTS)
      begin
        short_done_take <= pwdata_i[sts_pkg::SHORT_DONE_TAKE_BIT]; // [R8]
      end
    end
  end

  // Event flags: a zero written clears, but a new event in that cycle wins.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ev_flag <= '0;
    end
    else
    begin
      ev_flag.done <= ev_pulse.done
        | (ev_flag.done & ~(wr_acc && paddr_i == sts_pkg::OFS_EV_DONE && !pwdata_i[0]));
      ev_flag.rx_end <= ev_pulse.rx_end
        | (ev_flag.rx_end & ~(wr_acc && paddr_i == sts_pkg::OFS_EV_RXEND && !pwdata_i[0])); // [R5]
      ev_flag.taken <= ev_pulse.taken
        | (ev_flag.taken & ~(wr_acc && paddr_i == sts_pkg::OFS_EV_TAKEN && !pwdata_i[0])); // [R6]
    end
  end

  // Error status bits, cleared by writing one; a new error beats the clear.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stat_tx_overrun_read <= 1'b0;
      stat_overflow <= 1'b0;
    end
    else
    begin
      stat_tx_overrun_read <= tx_overrun_read_i | (stat_tx_overrun_read
        & ~(wr_acc && paddr_i == sts_pkg::OFS_STATUS && pwdata_i[sts_pkg::STAT_TX_OVERRUN_READ_BIT])); // [R15]
      stat_overflow <= overflow_i | (stat_overflow
        & ~(wr_acc && paddr_i == sts_pkg::OFS_STATUS && pwdata_i[sts_pkg::STAT_OVERFLOW_BIT])); // [R15]
    end
  end

  // Shared interrupt enables, reached through the set and clear views.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_en <= '0;
    end
    else if (wr_acc && paddr_i == sts_pkg::OFS_IEN_SET)
    begin
      irq_en <= irq_en | pwdata_i[sts_pkg::EVT_W-1:0]; // [R10] [R11]
    end
    else if (wr_acc && paddr_i == sts_pkg::OFS_IEN_CLR)
    begin
      irq_en <= irq_en & ~pwdata_i[sts_pkg::EVT_W-1:0]; // [R13]
    end
  end

  // Sticky interrupt status; written ones clear, and a same-cycle event wins.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_pend <= '0;
    end
    else if (wr_acc && paddr_i == sts_pkg::OFS_IRQ_PEND)
    begin
      irq_pend <= ev_pulse | (irq_pend & ~pwdata_i[sts_pkg::EVT_W-1:0]);
    end
    else
    begin
      irq_pend <= irq_pend | ev_pulse;
    end
  end

  // Level interrupt, from flops only so it never glitches.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(irq_pend & irq_en);
    end
  end

  // Published events drive a one-cycle pulse on their chosen channel.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      chan_o <= '0;
    end
    else
    begin
      chan_o <= link_drive(pub_done, ev_pulse.done) // [R7]
        | link_drive(pub_rxend, ev_pulse.rx_end)
        | link_drive(pub_taken, ev_pulse.taken);
    end
  end

endmodule
`default_nettype wire

// ### inc/sts_pkg.sv
// Register map, field layout and shared types of the semaphore and event block.
`default_nettype none
package sts_pkg;
  // Register byte offsets.
  localparam logic [11:0] OFS_TAKE = 12'h024;
  localparam logic [11:0] OFS_GIVE = 12'h028;
  localparam logic [11:0] OFS_SUB_TAKE = 12'h0A4;
  localparam logic [11:0] OFS_SUB_GIVE = 12'h0A8;
  localparam logic [11:0] OFS_EV_DONE = 12'h104;
  localparam logic [11:0] OFS_EV_RXEND = 12'h110;
  localparam logic [11:0] OFS_EV_TAKEN = 12'h128;
  localparam logic [11:0] OFS_PUB_DONE = 12'h184;
  localparam logic [11:0] OFS_PUB_RXEND = 12'h190;
  localparam logic [11:0] OFS_PUB_TAKEN = 12'h1A8;
  localparam logic [11:0] OFS_EVENT_TASK_SHORTCUTS = 12'h200;
  localparam logic [11:0] OFS_IRQ_PEND = 12'h300;
  localparam logic [11:0] OFS_IEN_SET = 12'h304;
  localparam logic [11:0] OFS_IEN_CLR = 12'h308;
  localparam logic [11:0] OFS_OWNER = 12'h400;
  localparam logic [11:0] OFS_STATUS = 12'h440;
  localparam logic [11:0] OFS_BITCNT = 12'h444;
  // Field positions.
  localparam int TRIG_BIT = 0;
  localparam int LINK_EN_BIT = 31;
  localparam int LINK_IDX_W = 8;
  localparam int SHORT_DONE_TAKE_BIT = 0;
  localparam int STAT_TX_OVERRUN_READ_BIT = 0;
  localparam int STAT_OVERFLOW_BIT = 1;
  localparam int EVT_W = 3;
  localparam int BITCNT_W = 16;
  // Reset values.
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // Channel link: enable plus channel index.
  typedef struct packed {
    logic en;
    logic [LINK_IDX_W-1:0] idx;
  } sts_link_type;
  // Event vector, bit 0 done, bit 1 receive end, bit 2 semaphore taken.
  typedef struct packed {
    logic taken;
    logic rx_end;
    logic done;
  } sts_evt_type;
  // Semaphore owner; the encoding is also the reported owner value.
  typedef enum logic [1:0] {
    SEM_FREE = 2'h0,
    SEM_CPU = 2'h1,
    SEM_ENG = 2'h2,
    SEM_PEND = 2'h3
  } sts_sem_type;
  localparam sts_sem_type SEM_RESET = SEM_CPU;
endpackage
`default_nettype wire

// ### testbench/sts_semaphore_events_properties.sv
// Port-level concurrent checks for the semaphore and event block.
`default_nettype none
module sts_semaphore_events_properties #(
  parameter int NUM_CHAN = 256
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic spi_csn_i,
  input wire logic spi_sck_i,
  input wire logic rx_end_i,
  input wire logic tx_overrun_read_i,
  input wire logic overflow_i,
  input wire logic [NUM_CHAN-1:0] chan_i,
  input wire logic [NUM_CHAN-1:0] chan_o,
  input wire logic engine_owns_o,
  input wire logic irq_o
);
  logic [2:0] csn_hi_cnt;
  // Idle time of the select pin; a take may only be judged when no grant can race it.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      csn_hi_cnt <= 3'h0;
    else if (!spi_csn_i)
      csn_hi_cnt <= 3'h0;
    else if (csn_hi_cnt != 3'h7)
      csn_hi_cnt <= csn_hi_cnt + 3'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // One completed APB access phase to a given address and direction.
  sequence s_acc(logic [11:0] a, logic w);
    psel_i && penable_i && paddr_i == a && pwrite_i == w;
  endsequence
  AST_PREADY_ZERO_WAIT: assert property (pready_o == (psel_i && penable_i))
    else $error("pready does not follow the access phase");
  AST_SLVERR_ACCESS: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("slave error outside an access phase");
  AST_OWNER_READ: assert property (s_acc(sts_pkg::OFS_OWNER, 1'b0) |->
    prdata_o[31:2] == 30'h0 && prdata_o[1] == $past(engine_owns_o))
    else $error("owner read disagrees with engine ownership");
  AST_TRIG_READ_ZERO: assert property (psel_i && penable_i && !pwrite_i &&
    (paddr_i == sts_pkg::OFS_TAKE || paddr_i == sts_pkg::OFS_GIVE) |-> prdata_o == 32'h0)
    else $error("trigger register reads nonzero");
  AST_GRANT_NEEDS_SELECT: assert property ($rose(engine_owns_o) |->
    !$past(spi_csn_i) && !$past(spi_csn_i, 2))
    else $error("engine granted without a selected frame");
  AST_FREE_NEEDS_DESELECT: assert property ($fell(engine_owns_o) |->
    $past(spi_csn_i) && $past(spi_csn_i, 2))
    else $error("engine released while still selected");
  AST_TAKE_NO_GRANT: assert property (s_acc(sts_pkg::OFS_TAKE, 1'b1) ##0
    (pwdata_i[0] && !engine_owns_o && csn_hi_cnt == 3'h7) |=> !engine_owns_o)
    else $error("take request handed the buffers to the engine");
  AST_IEN_CLR_MASKS: assert property (s_acc(sts_pkg::OFS_IEN_CLR, 1'b1) ##0
    pwdata_i[2:0] == 3'h7 |-> ##2 !irq_o)
    else $error("interrupt stays high after all enables cleared");
endmodule
bind sts_semaphore_events sts_semaphore_events_properties #(.NUM_CHAN(NUM_CHAN)) i_sts_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .spi_csn_i(spi_csn_i), .spi_sck_i(spi_sck_i),
  .rx_end_i(rx_end_i), .tx_overrun_read_i(tx_overrun_read_i), .overflow_i(overflow_i), .chan_i(chan_i),
  .chan_o(chan_o), .engine_owns_o(engine_owns_o), .irq_o(irq_o));
`default_nettype wire

// ### testbench/sts_spi_master.sv
// Behavioural SPI master that drives select and clock frames at the link rate.
`default_nettype none
module sts_spi_master (
  output logic csn_o,
  output logic sck_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lclk = 1'b0;
  // Link clock of 64 ns, started at an odd offset so it never lines up with a rising edge of the system clock.
  initial
  begin
    csn_o = 1'b1;
    sck_o = 1'b0;
    #11;
    forever
      #32 lclk = ~lclk;
  end
  // One frame of n clock pulses; the clock stands low outside frames.
  task automatic frame(input int n);
    @(posedge lclk);
    csn_o <= 1'b0;
    repeat (n)
    begin
      @(negedge lclk);
      sck_o <= 1'b1;
      @(posedge lclk);
      sck_o <= 1'b0;
    end
    @(negedge lclk);
    csn_o <= 1'b1;
    repeat (2)
      @(posedge lclk);
  endtask
endmodule
`default_nettype wire

// ### testbench/sts_semaphore_events_tb.sv
// Self-checking bench for the semaphore and event block.
`default_nettype none
module sts_semaphore_events_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic csn;
  logic sck;
  logic [2:0] ev = 3'h0;
  logic [255:0] chan = 256'h0;
  logic [255:0] chan_out;
  logic [255:0] seen;
  logic owns;
  logic irq;
  logic [31:0] q;
  logic err;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [11:0] rst_tab [16] = '{sts_pkg::OFS_TAKE, sts_pkg::OFS_GIVE, sts_pkg::OFS_SUB_TAKE,
    sts_pkg::OFS_SUB_GIVE, sts_pkg::OFS_EV_DONE, sts_pkg::OFS_EV_RXEND, sts_pkg::OFS_EV_TAKEN,
    sts_pkg::OFS_PUB_DONE, sts_pkg::OFS_PUB_RXEND, sts_pkg::OFS_PUB_TAKEN, sts_pkg::OFS_EVENT_TASK_SHORTCUTS,
    sts_pkg::OFS_IRQ_PEND, sts_pkg::OFS_IEN_SET, sts_pkg::OFS_IEN_CLR, sts_pkg::OFS_STATUS,
    sts_pkg::OFS_BITCNT};
  sts_semaphore_events #(.NUM_CHAN(256)) i_sts_semaphore_events (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .spi_csn_i(csn), .spi_sck_i(sck), .rx_end_i(ev[0]),
    .tx_overrun_read_i(ev[1]), .overflow_i(ev[2]), .chan_i(chan), .chan_o(chan_out),
    .engine_owns_o(owns), .irq_o(irq));
  sts_spi_master i_sts_spi_master (.csn_o(csn), .sck_o(sck));
  always #2.5 clk_i = ~clk_i;
  // Collects every published channel pulse; a hang is cut short by the cycle ceiling.
  always @(posedge clk_i)
  begin
    seen <= rst_n_i ? (seen | chan_out) : 256'h0;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors = errors + 1;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string nm);
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1)
      @(posedge clk_i);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(e, q, $sformatf("register %h", a));
  endtask
  task automatic tick(input int n);
    repeat (n)
      @(posedge clk_i);
  endtask
  // Engine-side pulses: bit 0 receive end, bit 1 over-read, bit 2 overflow.
  task automatic pulse(input logic [2:0] m);
    ev <= m;
    @(posedge clk_i);
    ev <= 3'h0;
    tick(4);
  endtask
  task automatic cpulse(input int k);
    chan[k] <= 1'b1;
    @(posedge clk_i);
    chan[k] <= 1'b0;
    tick(2);
  endtask
  task automatic final_report();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence: reset values, frames, shortcut, interrupts, channel links, status.
  initial
  begin
    tick(3);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    foreach (rst_tab[i])
      rd(rst_tab[i], 32'h0);
    rd(sts_pkg::OFS_OWNER, 32'h1);
    chk(32'h0, {31'h0, owns}, "engine owns");
    wr(12'hFFC, 32'h1);
    chk(32'h1, {31'h0, err}, "unmapped error");
    wr(sts_pkg::OFS_PUB_DONE, 32'h8000_0001);
    wr(sts_pkg::OFS_PUB_RXEND, 32'h8000_0003);
    wr(sts_pkg::OFS_PUB_TAKEN, 32'h8000_000C);
    wr(sts_pkg::OFS_GIVE, 32'h1);
    rd(sts_pkg::OFS_OWNER, 32'h0);
    // A take in mid-frame is deferred until the frame ends.
    fork
      i_sts_spi_master.frame(16);
      begin
        tick(40);
        rd(sts_pkg::OFS_OWNER, 32'h2);
        chk(32'h1, {31'h0, owns}, "engine owns");
        wr(sts_pkg::OFS_TAKE, 32'h1);
        rd(sts_pkg::OFS_OWNER, 32'h3);
        chk(32'h1, {31'h0, owns}, "engine owns");
      end
    join
    tick(8);
    rd(sts_pkg::OFS_OWNER, 32'h1);
    chk(32'h0, {31'h0, owns}, "engine owns");
    rd(sts_pkg::OFS_EV_DONE, 32'h1);
    rd(sts_pkg::OFS_EV_TAKEN, 32'h1);
    rd(sts_pkg::OFS_BITCNT, 32'h10);
    wr(sts_pkg::OFS_EV_DONE, 32'h0);
    wr(sts_pkg::OFS_EV_TAKEN, 32'h0);
    i_sts_spi_master.frame(8);
    tick(8);
    rd(sts_pkg::OFS_EV_DONE, 32'h0);
    wr(sts_pkg::OFS_TAKE, 32'h1);
    rd(sts_pkg::OFS_EV_TAKEN, 32'h0);
    wr(sts_pkg::OFS_EVENT_TASK_SHORTCUTS, 32'h1);
    wr(sts_pkg::OFS_GIVE, 32'h1);
    i_sts_spi_master.frame(8);
    tick(8);
    rd(sts_pkg::OFS_OWNER, 32'h1);
    rd(sts_pkg::OFS_EV_TAKEN, 32'h1);
    wr(sts_pkg::OFS_EVENT_TASK_SHORTCUTS, 32'h0);
    wr(sts_pkg::OFS_IRQ_PEND, 32'h7);
    wr(sts_pkg::OFS_IEN_SET, 32'h6);
    rd(sts_pkg::OFS_IEN_SET, 32'h6);
    rd(sts_pkg::OFS_IEN_CLR, 32'h6);
    pulse(3'h1);
    chk(32'h1, {31'h0, irq}, "irq");
    rd(sts_pkg::OFS_IRQ_PEND, 32'h2);
    rd(sts_pkg::OFS_EV_RXEND, 32'h1);
    wr(sts_pkg::OFS_EV_RXEND, 32'h0);
    rd(sts_pkg::OFS_EV_RXEND, 32'h0);
    wr(sts_pkg::OFS_IEN_CLR, 32'h2);
    tick(3);
    chk(32'h0, {31'h0, irq}, "irq");
    rd(sts_pkg::OFS_IEN_SET, 32'h4);
    wr(sts_pkg::OFS_SUB_GIVE, 32'h8000_0005);
    cpulse(5);
    rd(sts_pkg::OFS_OWNER, 32'h0);
    wr(sts_pkg::OFS_SUB_TAKE, 32'h0000_0009);
    cpulse(9);
    rd(sts_pkg::OFS_OWNER, 32'h0);
    wr(sts_pkg::OFS_SUB_TAKE, 32'h8000_0009);
    cpulse(9);
    rd(sts_pkg::OFS_OWNER, 32'h1);
    chk(32'h1, {31'h0, irq}, "irq");
    wr(sts_pkg::OFS_IEN_CLR, 32'h7);
    tick(3);
    chk(32'h0, {31'h0, irq}, "irq");
    pulse(3'h6);
    rd(sts_pkg::OFS_STATUS, 32'h3);
    wr(sts_pkg::OFS_STATUS, 32'h1);
    rd(sts_pkg::OFS_STATUS, 32'h2);
    chk(32'h0000_100A, seen[31:0], "published channels");
    chk(32'h0, {31'h0, |seen[255:32]}, "stray channels");
    final_report();
  end
endmodule
`default_nettype wire
